// *** lamp_pwm_pkg.sv ***
// Constants shared by the scanner lamp envelope and PWM block
package lamp_pwm_pkg;
  // ------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [29:0] LAMP2_ENVELOPE_EDGES_IDX = 30'h01ff88b0;
  localparam logic [29:0] LAMP0_PWM_CONFIG_IDX = 30'h01ff88b2;
  localparam logic [29:0] LAMP1_PWM_CONFIG_IDX = 30'h01ff88b4;
  localparam logic [29:0] LAMP2_PWM_CONFIG_IDX = 30'h01ff88b6;
  localparam logic [29:0] LAMP_OUTPUT_CONFIG_IDX = 30'h01ff88b8;
  localparam logic [29:0] LAMP_STATUS_IDX = 30'h01ff88bc;

  // ------------------------------------------------------------
  // Reset values and field layout
  // ------------------------------------------------------------
  localparam logic [15:0] EDGES_RESET = 16'h0000;
  localparam logic [10:0] PWM_CONFIG_RESET = 11'h000;
  localparam logic [5:0] OUTPUT_CONFIG_RESET = 6'h07;
  localparam int TRAIL_LSB = 8;
  localparam int LEAD_LSB = 0;
  localparam int DIV_LSB = 8;
  localparam int DUTY_LSB = 0;
  localparam int SYNC_LSB = 3;
  localparam int POS_LSB = 0;
  localparam int EDGE_UNIT_SHIFT = 6;
  localparam int NUM_LAMPS = 3;

  // ------------------------------------------------------------
  // Bus answers
  // ------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// *** scanner_lamp_envelope_pwm.sv ***
// Scanner lamp drive: per-line envelope gated with a prescaled 8-bit PWM
//
// Contract
// - Trailing edge at upper byte times 64 pixels.
// - Leading edge at lower byte times 64 pixels.
// - PWM clock is system clock over divider+1.
// - PWM period is 256 prescaled ticks, cyclic.
// - High time equals duty-cycle ticks per period.
// - Sync-select bits 5..3 bypass PWM and edges.
// - Sync mode follows enable, changes at cycle start.
// - Position bit measures leading edge from cycle start, without the delay.
module scanner_lamp_envelope_pwm
  import lamp_pwm_pkg::*;
#(
  parameter int PIX_W = 18
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic scan_cycle_start,
  input wire logic pixel_tick,
  input wire logic [15:0] line_start_delay,
  input wire logic [2:0] lamp_enable,
  input wire logic [15:0] lamp0_envelope_edges,
  input wire logic [15:0] lamp1_envelope_edges,
  output logic [2:0] lamp_drive_out
);
  import lamp_pwm_pkg::*;

  // Elaboration check: the pixel counter must reach 255*64 plus the delay
  if (PIX_W < 18)
  begin : g_bad_width
    $error("PIX_W must be at least 18");
  end

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [15:0] edges2_q;
  logic [10:0] pwm_cfg_q [NUM_LAMPS];
  logic [5:0] out_cfg_q;
  logic [31:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_full_q;
  logic w_full_q;

  // ----------------------------------------------------------------
  // AXI4-Lite decode
  // ----------------------------------------------------------------
  wire wr_fire = ce && aw_full_q && w_full_q && !s_axi_bvalid;
  wire [29:0] wr_idx = awaddr_q[31:2];
  wire [29:0] rd_idx = s_axi_araddr[31:2];
  wire wr_edges = wr_idx == LAMP2_ENVELOPE_EDGES_IDX;
  wire wr_pwm0 = wr_idx == LAMP0_PWM_CONFIG_IDX;
  wire wr_pwm1 = wr_idx == LAMP1_PWM_CONFIG_IDX;
  wire wr_pwm2 = wr_idx == LAMP2_PWM_CONFIG_IDX;
  wire wr_cfg = wr_idx == LAMP_OUTPUT_CONFIG_IDX;
  wire wr_hit = wr_edges || wr_pwm0 || wr_pwm1 || wr_pwm2 || wr_cfg || wr_idx == LAMP_STATUS_IDX;
  wire [2:0] wr_pwm = {wr_pwm2, wr_pwm1, wr_pwm0};
  wire [15:0] wmask = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  wire [15:0] wnew = wdata_q[15:0];
  wire rd_fire = ce && s_axi_arvalid && s_axi_arready;
  logic [2:0] sync_on_q;
  wire [31:0] status_w = {26'h0, sync_on_q, lamp_drive_out};
  wire rd_hit = rd_idx == LAMP2_ENVELOPE_EDGES_IDX || rd_idx == LAMP0_PWM_CONFIG_IDX
    || rd_idx == LAMP1_PWM_CONFIG_IDX || rd_idx == LAMP2_PWM_CONFIG_IDX
    || rd_idx == LAMP_OUTPUT_CONFIG_IDX || rd_idx == LAMP_STATUS_IDX;
  wire [31:0] rd_mux =
    (rd_idx == LAMP2_ENVELOPE_EDGES_IDX) ? {16'h0, edges2_q} :
    (rd_idx == LAMP0_PWM_CONFIG_IDX) ? {21'h0, pwm_cfg_q[0]} :
    (rd_idx == LAMP1_PWM_CONFIG_IDX) ? {21'h0, pwm_cfg_q[1]} :
    (rd_idx == LAMP2_PWM_CONFIG_IDX) ? {21'h0, pwm_cfg_q[2]} :
    (rd_idx == LAMP_OUTPUT_CONFIG_IDX) ? {26'h0, out_cfg_q} :
    (rd_idx == LAMP_STATUS_IDX) ? status_w : 32'h0;

  // Address and data are taken in either order; ready drops while one is held
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      awaddr_q <= 32'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awaddr_q <= s_axi_awaddr;
        aw_full_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_full_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_DECERR;
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Writable registers; the status word ignores writes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      edges2_q <= EDGES_RESET;
      out_cfg_q <= OUTPUT_CONFIG_RESET;
    end
    else if (wr_fire)
    begin
      if (wr_edges)
        edges2_q <= (edges2_q & ~wmask) | (wnew & wmask);
      if (wr_cfg && wstrb_q[0])
        out_cfg_q <= wnew[5:0];
    end
  end

  // Single read answer, held until taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (ce)
    begin
      if (rd_fire)
      begin
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_DECERR;
        s_axi_rvalid <= 1'b1;
        s_axi_arready <= 1'b0;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pixel position within the scan cycle
  // ----------------------------------------------------------------
  logic [PIX_W-1:0] pix_cnt_q;
  wire pix_max = &pix_cnt_q;

  // Saturates so that a long cycle cannot wrap back into the envelope
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pix_cnt_q <= '0;
    else if (ce && scan_cycle_start)
      pix_cnt_q <= '0;
    else if (ce && pixel_tick && !pix_max)
      pix_cnt_q <= pix_cnt_q + 1'b1;
  end

  // ----------------------------------------------------------------
  // Per-lamp envelope, prescaler, PWM and output
  // ----------------------------------------------------------------
  logic [2:0] pre_q [NUM_LAMPS];
  logic [7:0] pwm_cnt_q [NUM_LAMPS];
  wire [15:0] edges_w [NUM_LAMPS];
  wire [PIX_W-1:0] lead_w [NUM_LAMPS];
  wire [PIX_W-1:0] trail_w [NUM_LAMPS];
  wire [2:0] env_w;
  wire [2:0] tick_w;
  wire [2:0] pwm_hi_w;
  wire [2:0] sync_sel_w = out_cfg_q[SYNC_LSB +: 3];
  wire [2:0] pos_w = out_cfg_q[POS_LSB +: 3];
  wire [PIX_W-1:0] delay_w = PIX_W'(line_start_delay);

  assign edges_w[0] = lamp0_envelope_edges;
  assign edges_w[1] = lamp1_envelope_edges;
  assign edges_w[2] = edges2_q;

  for (genvar i = 0; i < NUM_LAMPS; i++)
  begin : g_lamp
    wire [2:0] div_w = pwm_cfg_q[i][DIV_LSB +: 3];
    wire [7:0] duty_w = pwm_cfg_q[i][DUTY_LSB +: 8];
    wire [PIX_W-1:0] lead_units = PIX_W'(edges_w[i][LEAD_LSB +: 8]) << EDGE_UNIT_SHIFT;
    wire [PIX_W-1:0] trail_units = PIX_W'(edges_w[i][TRAIL_LSB +: 8]) << EDGE_UNIT_SHIFT;
    assign lead_w[i] = pos_w[i] ? lead_units : lead_units + delay_w;
    assign trail_w[i] = trail_units + delay_w;
    assign env_w[i] = (pix_cnt_q >= lead_w[i]) && (pix_cnt_q < trail_w[i]);
    assign tick_w[i] = pre_q[i] == div_w;
    assign pwm_hi_w[i] = pwm_cnt_q[i] < duty_w;

    // Config register write, whole-byte granularity
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        pwm_cfg_q[i] <= PWM_CONFIG_RESET;
      else if (wr_fire && wr_pwm[i])
        pwm_cfg_q[i] <= (pwm_cfg_q[i] & ~wmask[10:0]) | (wnew[10:0] & wmask[10:0]);
    end

    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        pre_q[i] <= 3'h0;
        pwm_cnt_q[i] <= 8'h00;
      end
      else if (ce)
      begin
        pre_q[i] <= tick_w[i] ? 3'h0 : pre_q[i] + 3'h1;
        if (tick_w[i])
          pwm_cnt_q[i] <= pwm_cnt_q[i] + 8'h01;
      end
    end

    // enable latched only at cycle start, so in sync mode a disable finishes the cycle
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        sync_on_q[i] <= 1'b0;
      else if (ce && scan_cycle_start)
        sync_on_q[i] <= lamp_enable[i];
    end

    // sync bypass or envelope AND PWM, gated by the lamp enable
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
        lamp_drive_out[i] <= 1'b0;
      else if (ce)
        lamp_drive_out[i] <= sync_sel_w[i] ? sync_on_q[i]
          : (lamp_enable[i] && env_w[i] && pwm_hi_w[i]);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_normal2;
    ce && !sync_sel_w[2];
  endsequence

  property p_trail;
    s_normal2 and (pix_cnt_q >= trail_w[2]) |=> !lamp_drive_out[2];
  endproperty
  a_trail: assert property (p_trail) else $error("lamp 2 high after trailing edge");

  property p_lead;
    s_normal2 and (pix_cnt_q < lead_w[2]) |=> !lamp_drive_out[2];
  endproperty
  a_lead: assert property (p_lead) else $error("lamp 2 high before leading edge");

  property p_prescale;
    ce && tick_w[0] ##1 ce [*3] |-> pre_q[0] == 3'h2 || pwm_cfg_q[0][DIV_LSB +: 3] < 3'h2;
  endproperty
  a_prescale: assert property (p_prescale) else $error("prescaler count wrong");

  property p_wrap;
    ce && tick_w[1] && pwm_cnt_q[1] == 8'hff |=> pwm_cnt_q[1] == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("PWM period did not wrap at 256");

  property p_duty;
    ce && !sync_sel_w[0] && lamp_enable[0] && env_w[0]
      |=> lamp_drive_out[0] == $past(pwm_hi_w[0]);
  endproperty
  a_duty: assert property (p_duty) else $error("lamp 0 output disagrees with duty");

  property p_sync;
    ce && sync_sel_w[1] |=> lamp_drive_out[1] == $past(sync_on_q[1]);
  endproperty
  a_sync: assert property (p_sync) else $error("sync mode output not from enable");

  sequence s_mid_cycle;
    !scan_cycle_start [*2];
  endsequence

  property p_hold;
    s_mid_cycle |-> $stable(sync_on_q);
  endproperty
  a_hold: assert property (p_hold) else $error("sync state changed inside a cycle");

  property p_origin;
    pos_w[2] |-> lead_w[2] == (PIX_W'(edges2_q[7:0]) << EDGE_UNIT_SHIFT);
  endproperty
  a_origin: assert property (p_origin) else $error("leading edge origin wrong");

  property p_gate;
    ce && !sync_sel_w[1] && !env_w[1] |=> !lamp_drive_out[1];
  endproperty
  a_gate: assert property (p_gate) else $error("lamp 1 high outside envelope");
endmodule

// *** lamp_load.sv ***
// Lamp load model: counts lit cycles and edge times of each lamp drive
module lamp_load (
  input wire logic aclk,
  input wire logic clr,
  input wire logic [2:0] drive,
  output logic [2:0][15:0] hi_cnt,
  output logic [2:0][15:0] rise_t,
  output logic [2:0][15:0] last_t
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] t_q;
  // Times count from the clear pulse; an all-ones rise time means never lit
  always_ff @(posedge aclk)
  begin
    if (clr)
    begin
      t_q <= '0;
      hi_cnt <= '0;
      rise_t <= '1;
      last_t <= '0;
    end
    else
    begin
      t_q <= t_q + 16'h0001;
      for (int i = 0; i < 3; i++)
      begin
        // An unknown drive is not counted, so it shows up as a short count
        if (drive[i] === 1'b1)
        begin
          hi_cnt[i] <= hi_cnt[i] + 16'h0001;
          last_t[i] <= t_q;
          if (rise_t[i] == 16'hffff)
            rise_t[i] <= t_q;
        end
      end
    end
  end
endmodule

// *** tb_top.sv ***
// Self-checking bench for the scanner lamp envelope and PWM block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import lamp_pwm_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata, d;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic scan_start = 1'b0, pix = 1'b0, clr = 1'b0;
  logic [15:0] delay = '0, e0 = '0, e1 = '0, t0;
  logic [2:0] en = '0, lamp;
  logic [2:0][15:0] hi, rs, ls, h, rs_v, ls_v;
  logic [29:0] ridx [5] = '{LAMP2_ENVELOPE_EDGES_IDX, LAMP0_PWM_CONFIG_IDX,
    LAMP1_PWM_CONFIG_IDX, LAMP2_PWM_CONFIG_IDX, LAMP_OUTPUT_CONFIG_IDX};
  logic [31:0] rst_v [5] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h7};
  logic [31:0] all_v [5] = '{32'hffff, 32'h7ff, 32'h7ff, 32'h7ff, 32'h3f};
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;

  scanner_lamp_envelope_pwm DUT (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .scan_cycle_start(scan_start), .pixel_tick(pix), .line_start_delay(delay),
    .lamp_enable(en), .lamp0_envelope_edges(e0), .lamp1_envelope_edges(e1),
    .lamp_drive_out(lamp));
  lamp_load load (.aclk(aclk), .clr(clr), .drive(lamp), .hi_cnt(hi), .rise_t(rs), .last_t(ls));

  // ----------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------
  always #50 aclk = ~aclk;

  // The whole run needs under 8000 cycles; a hang is cut off well after that
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Edge placement tolerates one cycle, as the free-running PWM may be low at a boundary
  function automatic logic [31:0] near(input logic [31:0] a, input logic [31:0] b);
    return ((a > b) ? a - b : b - a) <= 32'h1;
  endfunction

  task automatic wr(input logic [29:0] idx, input logic [31:0] dv, output logic [1:0] rv);
    awaddr <= {idx, 2'b00};
    wdata <= dv;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid)
      begin
        rv = bresp;
        bready <= 1'b0;
      end
    end while (awvalid || wvalid || bready);
    // Let one edge pass so a following call never re-raises bready in the same step
    @(posedge aclk);
  endtask

  task automatic rd(input logic [29:0] idx, output logic [31:0] dv, output logic [1:0] rv);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid)
      begin
        dv = rdata;
        rv = rresp;
        rready <= 1'b0;
      end
    end while (arvalid || rready);
    // Let one edge pass so a following call never re-raises rready in the same step
    @(posedge aclk);
  endtask

  // Start a scan cycle, clear the load model, then capture its counts after n cycles
  task automatic run(input int n);
    scan_start <= 1'b1;
    clr <= 1'b1;
    @(posedge aclk);
    scan_start <= 1'b0;
    clr <= 1'b0;
    repeat (n) @(posedge aclk);
    #1;
    h = hi;
    rs_v = rs;
    ls_v = ls;
    @(posedge aclk);
  endtask

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 5; i++)
    begin
      rd(ridx[i], d, r);
      chk(d, rst_v[i]);
      wr(ridx[i], 32'hffffffff, r);
      chk(r, RESP_OKAY);
      rd(ridx[i], d, r);
      chk(d, all_v[i]);
    end
    wr(30'h01ff88b1, 32'h1, r);
    chk(r, RESP_DECERR);
    rd(30'h01ff88b1, d, r);
    chk(r, RESP_DECERR);
    chk(d, 32'h0);
    $display("test registers done");
    en <= 3'b111;
    e0 <= 16'hff00;
    e1 <= 16'hff00;
    wr(LAMP2_ENVELOPE_EDGES_IDX, 32'hff00, r);
    wr(LAMP_OUTPUT_CONFIG_IDX, 32'h0, r);
    wr(LAMP0_PWM_CONFIG_IDX, 32'h0040, r);
    wr(LAMP1_PWM_CONFIG_IDX, 32'h03ff, r);
    wr(LAMP2_PWM_CONFIG_IDX, 32'h0780, r);
    run(2048);
    chk(h[0], 32'd512);
    chk(h[1], 32'd2040);
    chk(h[2], 32'd1024);
    $display("test pwm done");
    en <= 3'b100;
    pix <= 1'b1;
    delay <= 16'd10;
    wr(LAMP2_PWM_CONFIG_IDX, 32'h00ff, r);
    wr(LAMP2_ENVELOPE_EDGES_IDX, 32'h0201, r);
    run(300);
    t0 = rs_v[2];
    chk(near(ls_v[2] - rs_v[2] + 16'h1, 32'd64), 32'h1);
    chk(near(h[2], 32'd64), 32'h1);
    chk(h[0] | h[1], 32'h0);
    wr(LAMP_OUTPUT_CONFIG_IDX, 32'h4, r);
    run(300);
    chk(near(t0 - rs_v[2], 32'd10), 32'h1);
    chk(near(ls_v[2] - rs_v[2] + 16'h1, 32'd74), 32'h1);
    $display("test envelope done");
    wr(LAMP2_PWM_CONFIG_IDX, 32'h0, r);
    wr(LAMP2_ENVELOPE_EDGES_IDX, 32'h0, r);
    wr(LAMP_OUTPUT_CONFIG_IDX, 32'h20, r);
    run(300);
    chk(h[2] >= 16'd297, 32'h1);
    rd(LAMP_STATUS_IDX, d, r);
    chk(d, 32'h24);
    en <= 3'b000;
    repeat (50) @(posedge aclk);
    chk(lamp[2], 32'h1);
    run(5);
    chk(lamp[2], 32'h0);
    en <= 3'b100;
    run(5);
    chk(lamp[2], 32'h1);
    $display("test sync done");
    conclude();
  end
endmodule
